// File: design/dds_stage_pkg.sv
// Package of constants, register map and carrier types for the staged synthesis engine.
// Overview of operation
// - 32-bit accumulator addresses lookup, 12-bit output path.
// - Lookup holds 16384 samples of 16 bits.
// - Lookup serves synthesis and arb modes.
// - Accumulator wraps naturally past lookup end.
// - Accumulator adds word every 40 MHz update while a stage runs; it holds in idle and wait.
// - Output frequency is word times clock over 2^32.
// - Lookup address is top 14 accumulator bits.
// - Stage is frequency word plus time word.
// - All stages share one lookup buffer.
// - Stage change keeps phase, swaps increment only.
// - Instruction store holds 340 stages.
// - Trigger source: software default, pin, bus line.
// - External triggers act on rising edge.
// - Single, continuous, stepped and burst modes.
// - Single runs list once, last stage repeats.
// - Continuous loops list until stopped.
// - Stepped: one stage per trigger, wraps.
// - Stepped arb ignores triggers during a stage.
// - Stepped arb repeats the lookup's first eight samples.
// - Synthesis stepped and burst behave the same.
// - Burst runs stage until trigger, then advances; arb burst here ends the stage at its dwell and waits like stepped arb.
// - Only the top 12 sample bits are forwarded.
package dds_stage_pkg;
  localparam int ACC_W = 32;
  localparam int ADDR_W = 14;
  localparam int SAMPLE_W = 16;
  localparam int DAC_W = 12;
  localparam int LUT_DEPTH = 16384;
  localparam int STAGES = 340;
  localparam int STAGE_IDX_W = 9;
  localparam int TRIG_LINES = 7;
  localparam int TRIG_SEL_W = 3;
  localparam int UPDATE_HZ = 40000000;
  localparam int MIN_DWELL_NS = 2000;
  localparam int MIN_DWELL_CYC = (MIN_DWELL_NS * (UPDATE_HZ / 1000000) + 999) / 1000;
  // Register byte offsets.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] LUT_ADDR_OFS = 12'h008;
  localparam logic [11:0] LUT_DATA_OFS = 12'h00c;
  localparam logic [11:0] STG_IDX_OFS = 12'h010;
  localparam logic [11:0] STG_FREQ_OFS = 12'h014;
  localparam logic [11:0] STG_TIME_OFS = 12'h018;
  localparam logic [11:0] STG_COUNT_OFS = 12'h01c;
  localparam logic [11:0] CMD_OFS = 12'h020;
  localparam logic [11:0] PHASE_OFS = 12'h024;
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_LINE_LSB = 4;
  localparam int CTRL_ARB_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Command register fields, write one to act.
  localparam int CMD_SW_TRIG = 0;
  localparam int CMD_STOP = 1;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_STEPPED, MODE_BURST} trig_mode_e;
  typedef enum logic [1:0] {SRC_SOFT, SRC_PIN, SRC_BUS, SRC_NONE} trig_src_e;
  typedef struct packed {
    logic [ACC_W-1:0] freq;
    logic [31:0] dwell;
  } stage_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage : dds_stage_pkg

// File: design/dds_stage_sequencer.sv
// Direct synthesis engine with staged frequency-hop sequencer and APB registers.
`timescale 1ns/1ps
module dds_stage_sequencer (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire dds_stage_pkg::apb_req_s apb_in,
  input wire logic ext_trig_in,
  input wire logic [dds_stage_pkg::TRIG_LINES-1:0] instrument_trigger_bus_in,
  input wire logic update_en_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [dds_stage_pkg::DAC_W-1:0] dac_data_out,
  output logic dac_valid_out
);
  // ************************************************************
  // Registers and storage
  // ************************************************************
  logic [31:0] ctrl;
  logic [dds_stage_pkg::ADDR_W-1:0] lut_addr;
  logic [dds_stage_pkg::SAMPLE_W-1:0] lut [dds_stage_pkg::LUT_DEPTH];
  dds_stage_pkg::stage_s stage_mem [dds_stage_pkg::STAGES];
  logic [dds_stage_pkg::STAGE_IDX_W-1:0] stg_idx;
  logic [dds_stage_pkg::STAGE_IDX_W-1:0] stg_count;
  logic [dds_stage_pkg::ACC_W-1:0] acc;
  logic [dds_stage_pkg::ACC_W-1:0] incr;
  logic [31:0] dwell_cnt;
  logic [dds_stage_pkg::STAGE_IDX_W-1:0] cur;
  logic running;
  logic waiting;
  logic pend_trig;
  logic trig_q;
  logic [2:0] arb_hold;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} seq_state_e;
  seq_state_e state;

  dds_stage_pkg::trig_mode_e mode;
  dds_stage_pkg::trig_src_e src;
  logic arb_mode;
  assign mode = dds_stage_pkg::trig_mode_e'(ctrl[dds_stage_pkg::CTRL_MODE_LSB +: 2]);
  assign src = dds_stage_pkg::trig_src_e'(ctrl[dds_stage_pkg::CTRL_SRC_LSB +: 2]);
  assign arb_mode = ctrl[dds_stage_pkg::CTRL_ARB_BIT];

  // ************************************************************
  // APB decode
  // ************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out;
  assign rd_acc = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
  assign mapped = hit(apb_in.paddr, dds_stage_pkg::CTRL_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::STATUS_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::LUT_ADDR_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::LUT_DATA_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::STG_IDX_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::STG_FREQ_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::STG_TIME_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::STG_COUNT_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::CMD_OFS)
    || hit(apb_in.paddr, dds_stage_pkg::PHASE_OFS);

  logic cmd_trig;
  logic cmd_stop;
  assign cmd_trig = wr_acc && hit(apb_in.paddr, dds_stage_pkg::CMD_OFS)
    && apb_in.pwdata[dds_stage_pkg::CMD_SW_TRIG];
  assign cmd_stop = wr_acc && hit(apb_in.paddr, dds_stage_pkg::CMD_OFS)
    && apb_in.pwdata[dds_stage_pkg::CMD_STOP];

  // Ready one cycle after setup: the access phase is always exactly one cycle long.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_in.psel && !apb_in.penable;
      pslverr_out <= apb_in.psel && !apb_in.penable && !mapped;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_acc) begin
      unique case (apb_in.paddr)
        dds_stage_pkg::CTRL_OFS: prdata_out <= ctrl;
        dds_stage_pkg::STATUS_OFS: prdata_out <= {20'h00000, 2'(state), 1'b0, cur};
        dds_stage_pkg::LUT_ADDR_OFS: prdata_out <= {18'h00000, lut_addr};
        dds_stage_pkg::LUT_DATA_OFS: prdata_out <= {16'h0000, lut[lut_addr]};
        dds_stage_pkg::STG_IDX_OFS: prdata_out <= {23'h000000, stg_idx};
        dds_stage_pkg::STG_FREQ_OFS: prdata_out <= stage_mem[stg_idx].freq;
        dds_stage_pkg::STG_TIME_OFS: prdata_out <= stage_mem[stg_idx].dwell;
        dds_stage_pkg::STG_COUNT_OFS: prdata_out <= {23'h000000, stg_count};
        dds_stage_pkg::PHASE_OFS: prdata_out <= acc;
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ctrl <= dds_stage_pkg::CTRL_RESET;
      lut_addr <= '0;
      stg_idx <= '0;
      stg_count <= '0;
    end else if (wr_acc) begin
      unique case (apb_in.paddr)
        dds_stage_pkg::CTRL_OFS: ctrl <= {24'h000000, apb_in.pwdata[7:0]};
        dds_stage_pkg::LUT_ADDR_OFS: lut_addr <= apb_in.pwdata[dds_stage_pkg::ADDR_W-1:0];
        // Auto-increment lets software stream a whole table through one port.
        dds_stage_pkg::LUT_DATA_OFS: lut_addr <= lut_addr + 14'h0001;
        dds_stage_pkg::STG_IDX_OFS: stg_idx <= apb_in.pwdata[dds_stage_pkg::STAGE_IDX_W-1:0];
        dds_stage_pkg::STG_COUNT_OFS: begin
          if (apb_in.pwdata[8:0] > 9'(dds_stage_pkg::STAGES)) begin
            stg_count <= 9'(dds_stage_pkg::STAGES);
          end else begin
            stg_count <= apb_in.pwdata[8:0];
          end
        end
        default: ;
      endcase
    end
  end

  // The lookup table feeds the synthesis path and the arb wait, which reads its first eight samples.
  always_ff @(posedge clk_sys_in) begin
    if (wr_acc && hit(apb_in.paddr, dds_stage_pkg::LUT_DATA_OFS)) begin
      lut[lut_addr] <= apb_in.pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (wr_acc && stg_idx < 9'(dds_stage_pkg::STAGES)) begin
      if (hit(apb_in.paddr, dds_stage_pkg::STG_FREQ_OFS)) begin
        stage_mem[stg_idx].freq <= apb_in.pwdata;
      end
      if (hit(apb_in.paddr, dds_stage_pkg::STG_TIME_OFS)) begin
        stage_mem[stg_idx].dwell <= apb_in.pwdata;
      end
    end
  end

  // ************************************************************
  // Trigger selection
  // ************************************************************
  logic sel_level;
  always_comb begin
    unique case (src)
      dds_stage_pkg::SRC_PIN: sel_level = ext_trig_in;
      // A line number past the last bus line reads as an idle line.
      dds_stage_pkg::SRC_BUS: sel_level = (int'(ctrl[6:4]) < dds_stage_pkg::TRIG_LINES)
        && instrument_trigger_bus_in[ctrl[6:4]];
      default: sel_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= sel_level;
    end
  end

  logic trig_evt;
  assign trig_evt = (src == dds_stage_pkg::SRC_SOFT) ? cmd_trig : (sel_level && !trig_q);

  // A trigger landing between update enables is held until the next update.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pend_trig <= 1'b0;
    end else if (cmd_stop) begin
      pend_trig <= 1'b0;
    end else if (trig_evt) begin
      pend_trig <= 1'b1;
    end else if (update_en_in) begin
      pend_trig <= 1'b0;
    end
  end

  // ************************************************************
  // Stage sequencer
  // ************************************************************
  logic last_stage;
  logic [dds_stage_pkg::STAGE_IDX_W-1:0] next_cur;
  logic dwell_done;
  logic step_like;
  assign last_stage = (cur + 9'h001 >= stg_count);
  assign next_cur = last_stage ? 9'h000 : cur + 9'h001;
  assign dwell_done = (dwell_cnt <= 32'h0000_0001);
  assign step_like = (mode == dds_stage_pkg::MODE_STEPPED) || (mode == dds_stage_pkg::MODE_BURST);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      cur <= '0;
      incr <= '0;
      dwell_cnt <= '0;
      arb_hold <= '0;
    end else if (cmd_stop) begin
      state <= ST_IDLE;
      incr <= '0;
    end else if (update_en_in) begin
      unique case (state)
        ST_IDLE: begin
          if (pend_trig && stg_count != 9'h000) begin
            state <= ST_RUN;
            cur <= '0;
            incr <= stage_mem[0].freq;
            dwell_cnt <= stage_mem[0].dwell;
          end
        end
        ST_RUN: begin
          if (step_like && !arb_mode) begin
            // Synthesis stepped and burst ignore dwell: the trigger paces the hop.
            if (pend_trig) begin
              cur <= next_cur;
              incr <= stage_mem[next_cur].freq;
            end
          end else if (dwell_done) begin
            if (mode == dds_stage_pkg::MODE_SINGLE && last_stage) begin
              dwell_cnt <= '0;
            end else if (step_like) begin
              state <= ST_WAIT;
              arb_hold <= '0;
            end else begin
              cur <= next_cur;
              incr <= stage_mem[next_cur].freq;
              dwell_cnt <= stage_mem[next_cur].dwell;
            end
          end else begin
            dwell_cnt <= dwell_cnt - 32'h0000_0001;
          end
        end
        ST_WAIT: begin
          arb_hold <= arb_hold + 3'h1;
          if (pend_trig) begin
            state <= ST_RUN;
            cur <= next_cur;
            incr <= stage_mem[next_cur].freq;
            dwell_cnt <= stage_mem[next_cur].dwell;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Phase accumulator and output
  // ************************************************************
  // In arb-stepped wait the address cycles the lookup's first eight samples.
  logic [dds_stage_pkg::ADDR_W-1:0] rd_addr;
  assign rd_addr = (state == ST_WAIT && arb_mode) ? {11'h000, arb_hold}
                                                  : acc[31 -: dds_stage_pkg::ADDR_W];

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      acc <= '0;
    end else if (update_en_in && state == ST_RUN) begin
      acc <= acc + incr;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      dac_data_out <= '0;
      dac_valid_out <= 1'b0;
    end else begin
      dac_valid_out <= update_en_in && state != ST_IDLE;
      if (update_en_in) begin
        dac_data_out <= lut[rd_addr][15 -: dds_stage_pkg::DAC_W];
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_stop_zero;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      cmd_stop |=> (incr == '0) && (state == ST_IDLE);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("stop left increment");
  property p_acc_add;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (update_en_in && state == ST_RUN && !cmd_stop) |=> acc == $past(acc) + $past(incr);
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("accumulator step wrong");
  property p_idle_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state == ST_IDLE) |=> acc == $past(acc);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("accumulator moved idle");
  property p_count_max;
    @(posedge clk_sys_in) disable iff (!rstn_in) stg_count <= 9'(dds_stage_pkg::STAGES);
  endproperty
  a_count_max: assert property (p_count_max) else $error("stage count too big");
  property p_dac_bits;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      update_en_in |=> dac_data_out === $past(lut[rd_addr][15:4]);
  endproperty
  a_dac_bits: assert property (p_dac_bits) else $error("dac bits wrong");
  property p_wait_trig;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state == ST_WAIT && !pend_trig && !cmd_stop) |=> state == ST_WAIT;
  endproperty
  a_wait_trig: assert property (p_wait_trig) else $error("left wait untriggered");
  property p_edge;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (src == dds_stage_pkg::SRC_PIN && ext_trig_in && trig_q && !cmd_stop) |=> !pend_trig
      || $past(pend_trig);
  endproperty
  a_edge: assert property (p_edge) else $error("level seen as trigger");
  property p_wrap;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (update_en_in && pend_trig && last_stage && !cmd_stop
        && (state == ST_WAIT || (state == ST_RUN && step_like && !arb_mode))) |=> cur == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stage did not wrap");
  c_start: cover property (@(posedge clk_sys_in) state == ST_IDLE ##1 state == ST_RUN);
  c_wait: cover property (@(posedge clk_sys_in) state == ST_RUN ##1 state == ST_WAIT);
  c_hop: cover property (@(posedge clk_sys_in) state == ST_RUN && $changed(cur));
endmodule : dds_stage_sequencer

// File: verification/dac_sink.sv
// Behavioural model of the converter path that takes each synthesised sample.
`timescale 1ns/1ps
module dac_sink (
  input wire logic clk_sys_in,
  input wire logic [dds_stage_pkg::DAC_W-1:0] dac_data_in,
  input wire logic dac_valid_in,
  output logic [dds_stage_pkg::DAC_W-1:0] last_out,
  output logic [31:0] beats_out
);
  initial begin
    last_out = '0;
    beats_out = '0;
  end
  // The converter cannot stall the engine, so every valid beat is taken at once.
  always @(posedge clk_sys_in) begin
    if (dac_valid_in === 1'b1) begin
      last_out <= dac_data_in;
      beats_out <= beats_out + 32'h1;
    end
  end
endmodule : dac_sink

// File: verification/tb.sv
// Self-checking bench for the staged synthesis engine and its APB registers.
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] CTL = dds_stage_pkg::CTRL_OFS;
  localparam logic [11:0] STA = dds_stage_pkg::STATUS_OFS;
  localparam logic [11:0] PHA = dds_stage_pkg::PHASE_OFS;
  localparam logic [11:0] CMD = dds_stage_pkg::CMD_OFS;
  localparam logic [11:0] CNT = dds_stage_pkg::STG_COUNT_OFS;
  localparam int D = dds_stage_pkg::MIN_DWELL_CYC;
  localparam logic [31:0] DW = 32'(D);
  localparam logic [31:0] SM = 32'h0000_0c00;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic err;
  } note_s;
  logic clk_sys_in;
  logic rstn_in;
  dds_stage_pkg::apb_req_s apb;
  logic ext_trig;
  logic [dds_stage_pkg::TRIG_LINES-1:0] trig_bus;
  logic update_en;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [dds_stage_pkg::DAC_W-1:0] dac_data;
  logic dac_valid;
  logic [dds_stage_pkg::DAC_W-1:0] dac_last;
  logic [31:0] dac_beats;
  logic [31:0] seed;
  logic [31:0] rdat;
  logic [31:0] p0;
  logic [31:0] f [3];
  int line;
  int fails;
  int total_checks;
  note_s notes[$];

  dds_stage_sequencer u_dds_stage_sequencer (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .apb_in(apb), .ext_trig_in(ext_trig), .instrument_trigger_bus_in(trig_bus),
    .update_en_in(update_en), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .dac_data_out(dac_data), .dac_valid_out(dac_valid));
  dac_sink u_dac_sink (.clk_sys_in(clk_sys_in), .dac_data_in(dac_data),
    .dac_valid_in(dac_valid), .last_out(dac_last), .beats_out(dac_beats));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic fail(input string msg);
    fails++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) fail(msg);
  endtask : check

  task automatic cmp_read(input note_s nt, input logic [31:0] got, input logic gerr);
    total_checks++;
    if ((got & nt.mask) !== (nt.exp & nt.mask) || gerr !== nt.err) fail("apb answer");
  endtask : cmp_read

  // Notes are taken off the queue in the cycle the slave answers.
  always @(posedge clk_sys_in) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) fail("stray pready");
      else cmp_read(notes.pop_front(), prdata, pslverr);
    end
  end

  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys_in);
    apb.penable <= 1'b1;
    // The request stands until the edge at which pready is sampled high.
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail("no pready");
      conclude();
    end
    rdat = prdata;
    apb <= '0;
    // One idle edge keeps the next setup out of this time step.
    @(posedge clk_sys_in);
  endtask : apb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic er);
    notes.push_back('{exp: 32'h0, mask: 32'h0, err: er});
    apb_xfer(1'b1, a, wd);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    notes.push_back('{exp: e, mask: m, err: er});
    apb_xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulses(input int k);
    repeat (k) begin
      update_en <= 1'b1;
      @(posedge clk_sys_in);
    end
    update_en <= 1'b0;
    @(posedge clk_sys_in);
  endtask : pulses

  task automatic stage(input int i, input logic [31:0] fr);
    wr(dds_stage_pkg::STG_IDX_OFS, 32'(i), 1'b0);
    wr(dds_stage_pkg::STG_FREQ_OFS, fr, 1'b0);
    wr(dds_stage_pkg::STG_TIME_OFS, DW, 1'b0);
  endtask : stage

  task automatic go(input logic [31:0] m);
    wr(CTL, m, 1'b0);
    wr(CMD, 32'h1, 1'b0);
    pulses(3);
  endtask : go

  // In continuous mode, any 3*D consecutive updates cover every stage of a three-stage list equally.
  task automatic window(input logic [31:0] e);
    rd(PHA, 32'h0, 32'h0, 1'b0);
    p0 = rdat;
    pulses(3 * D);
    rd(PHA, 32'h0, 32'h0, 1'b0);
    check(rdat - p0, e, "phase advance");
  endtask : window

  task automatic hit(input int s, input int ln);
    if (s == 1) ext_trig <= 1'b1;
    else trig_bus[ln] <= 1'b1;
    pulses(6);
    ext_trig <= 1'b0;
    trig_bus <= '0;
    pulses(2);
  endtask : hit

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    fail("timeout");
    conclude();
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    apb = '0;
    ext_trig = 1'b0;
    trig_bus = '0;
    update_en = 1'b0;
    rstn_in = 1'b0;
    seed = 32'h2de8e5ba;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(CTL, 32'h0, '1, 1'b0);
    rd(STA, 32'h0, SM, 1'b0);
    rd(12'h028, 32'h0, '1, 1'b1);
    wr(12'h028, 32'h5, 1'b1);
    wr(CNT, 32'd1000, 1'b0);
    rd(CNT, 32'd340, '1, 1'b0);
    $display("test registers done");
    seed = xs(seed);
    wr(dds_stage_pkg::LUT_ADDR_OFS, 32'h0, 1'b0);
    wr(dds_stage_pkg::LUT_DATA_OFS, {16'h0, seed[15:0]}, 1'b0);
    stage(0, 32'h0);
    wr(CNT, 32'd1, 1'b0);
    go(32'h1);
    pulses(20);
    check({20'h0, dac_last}, {20'h0, seed[15:4]}, "dac sample");
    check({31'h0, dac_beats != 0}, 32'h1, "dac beats");
    rd(PHA, 32'h0, '1, 1'b0);
    wr(CMD, 32'h2, 1'b0);
    $display("test sample path done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      f[i] = seed;
      stage(i, seed);
    end
    wr(CNT, 32'd3, 1'b0);
    go(32'h1);
    window(DW * (f[0] + f[1] + f[2]));
    wr(CMD, 32'h2, 1'b0);
    window(32'h0);
    rd(STA, 32'h0, SM, 1'b0);
    go(32'h0);
    pulses(4 * D);
    window(DW * 32'd3 * f[2]);
    rd(STA, 32'h402, 32'h0dff, 1'b0);
    wr(CMD, 32'h2, 1'b0);
    $display("test single and continuous done");
    for (int m = 2; m < 4; m++) begin
      go(32'(m));
      window(DW * 32'd3 * f[0]);
      wr(CMD, 32'h1, 1'b0);
      pulses(3);
      window(DW * 32'd3 * f[1]);
      repeat (2) begin
        wr(CMD, 32'h1, 1'b0);
        pulses(3);
      end
      rd(STA, 32'h400, 32'h0dff, 1'b0);
      wr(CMD, 32'h2, 1'b0);
    end
    $display("test stepped and burst done");
    seed = xs(seed);
    line = int'(seed % 7);
    for (int s = 1; s < 3; s++) begin
      wr(CTL, 32'h2 | 32'(s << 2) | 32'(line << 4), 1'b0);
      hit(s, line);
      hit(s, line);
      rd(STA, 32'h401, 32'h0dff, 1'b0);
      wr(CMD, 32'h2, 1'b0);
    end
    $display("test trigger sources done");
    go(32'h82);
    wr(CMD, 32'h1, 1'b0);
    pulses(D + 8);
    rd(STA, 32'h800, SM, 1'b0);
    wr(CMD, 32'h1, 1'b0);
    pulses(3);
    rd(STA, 32'h400, SM, 1'b0);
    wr(CMD, 32'h2, 1'b0);
    $display("test waiting step done");
    conclude();
  end
endmodule : tb
